// File: design/seq_pkg.sv
/*
  Shared constants for the motor start/stop sequencer: register map, mode
  field positions, reset values, state codes and the timing base.
  Assumes a 10 MHz bus clock and a 10 ms sequencing tick.
*/
package seq_pkg;

  // timing base
  localparam int CLK_PERIOD_NS  = 100;
  localparam int TICK_PERIOD_NS = 10_000_000;
  localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_W         = 17;
  // 0.1 s settings become ticks by this factor, 0.01 s settings are ticks already
  localparam logic [3:0] TICKS_PER_DECI = 4'hA;

  // register indices; byte address is index * 4
  localparam int NUM_CFG          = 20;
  localparam int IDX_CTRL         = 0;
  localparam int IDX_MODE         = 1;
  localparam int IDX_SET_FREQ     = 2;
  localparam int IDX_MAX_FREQ     = 3;
  localparam int IDX_LOWER_LIMIT  = 4;
  localparam int IDX_START_FREQ   = 5;
  localparam int IDX_START_HOLD   = 6;
  localparam int IDX_PRE_CUR      = 7;
  localparam int IDX_PRE_TIME     = 8;
  localparam int IDX_ACCEL        = 9;
  localparam int IDX_DECEL        = 10;
  localparam int IDX_S_START      = 11;
  localparam int IDX_S_END        = 12;
  localparam int IDX_BRK_FREQ     = 13;
  localparam int IDX_BRK_WAIT     = 14;
  localparam int IDX_BRK_CUR      = 15;
  localparam int IDX_BRK_TIME     = 16;
  localparam int IDX_DEADZONE     = 17;
  localparam int IDX_STOP_SPEED   = 18;
  localparam int IDX_STOP_DELAY   = 19;
  localparam int IDX_STATUS       = 20;
  localparam int IDX_OUT_FREQ     = 21;

  // control register bits
  localparam int CTRL_KEY_RUN  = 0;
  localparam int CTRL_KEY_REV  = 1;
  localparam int CTRL_COMM_RUN = 2;
  localparam int CTRL_COMM_REV = 3;
  localparam int CTRL_SVPWM    = 4;

  // mode register fields
  localparam int MODE_CHAN_LO   = 0;
  localparam int MODE_START_LO  = 2;
  localparam int MODE_SHAPE     = 4;
  localparam int MODE_STOP      = 5;
  localparam int MODE_REV_LO    = 6;
  localparam int MODE_DETECT    = 8;
  localparam int MODE_PROTECT   = 9;
  localparam int MODE_LOWACT_LO = 12;
  localparam int MODE_LOW_DECEL = 14;

  localparam logic [1:0] CHAN_KEYPAD   = 2'h0;
  localparam logic [1:0] CHAN_TERMINAL = 2'h1;
  localparam logic [1:0] CHAN_COMM     = 2'h2;
  localparam logic [1:0] START_DIRECT  = 2'h0;
  localparam logic [1:0] START_BRAKE   = 2'h1;
  localparam logic [1:0] START_TRACK2  = 2'h3;
  localparam logic [1:0] REV_AT_ZERO   = 2'h0;
  localparam logic [1:0] REV_AT_START  = 2'h1;
  localparam logic [1:0] LOW_RUN       = 2'h0;
  localparam logic [1:0] LOW_SLEEP     = 2'h2;

  // reset values, frequencies in 0.01 Hz, times in 0.1 s or 0.01 s, current in 0.1 %
  localparam logic [15:0] RESET_VAL [NUM_CFG] = '{
    16'h0000, 16'h0100, 16'h0000, 16'h1770, 16'h0000,
    16'h0032, 16'h0000, 16'h0000, 16'h0000, 16'h0064,
    16'h0064, 16'h0001, 16'h0001, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0032, 16'h0000};

  typedef enum logic [9:0] {
    ST_IDLE      = 10'h001,
    ST_PREBRAKE  = 10'h002,
    ST_TRACK     = 10'h004,
    ST_HOLD      = 10'h008,
    ST_RUN       = 10'h010,
    ST_STOPPING  = 10'h020,
    ST_BRK_WAIT  = 10'h040,
    ST_BRAKE     = 10'h080,
    ST_REVERSE   = 10'h100,
    ST_DEADZONE  = 10'h200
  } state_t;

endpackage

// File: design/seq_helpers.sv
/*
  Two small helpers: a two-stage input synchroniser and a tick-driven
  down-counting phase timer.
  Assumes one clock domain and an active-low asynchronous reset.
*/
`timescale 1ns/1ps

module seq_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] stage;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage <= '0;
      q     <= '0;
    end else begin
      stage <= d;
      q     <= stage;
    end
  end
endmodule

module seq_timer #(
  parameter int WIDTH = 20
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_val,
  input  wire logic             tick,
  output logic                  done
);
  logic [WIDTH-1:0] cnt;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (load) begin
      cnt <= load_val;
    end else if (tick && cnt != '0) begin
      cnt <= cnt - 1'b1;
    end
  end

  assign done = (cnt == '0);
endmodule

// File: design/motor_start_stop_sequencer.sv
/*
  Start/stop sequencer of a variable-frequency drive: start modes, linear or
  S ramp, decelerating stop with DC braking or coast stop, reversal, stop speed,
  power-on run protection and lower-limit action, set up over AHB-Lite.
  Assumes terminal inputs are asynchronous pins and speed_fb comes from
  logic on hclk.
  // Behaviour
  // - two-bit start mode picks start path
  // - direct start begins at starting frequency
  // - hold starting frequency for programmed time
  // - pre-start DC injection at programmed level
  // - pre-start braking time; zero skips it
  // - ramp shape straight or S curve
  // - stop by deceleration or by coasting
  // - stop braking starts below threshold frequency
  // - wait programmed interval before braking current
  // - stop braking applies programmed current
  // - stop braking held programmed time
  // - reversal turn point by mode plus deadzone
  // - stop speed from set or detected speed
  // - power-on terminal run ignored unless enabled
  // - below lower limit: run there or stop
  // - sleep action; coast or decelerate choice
*/
`timescale 1ns/1ps

module motor_start_stop_sequencer #(
  parameter int TICK_CYCLES = seq_pkg::TICK_CYCLES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        term_fwd,
  input  wire logic        term_rev,
  input  wire logic [15:0] speed_fb,
  output logic      [15:0] out_freq,
  output logic             out_reverse,
  output logic             out_enable,
  output logic             dc_brake_on,
  output logic      [15:0] dc_brake_level,
  output logic             drive_running,
  output logic             drive_sleep
);
  import seq_pkg::*;

  logic [15:0] cfg [NUM_CFG];
  state_t      state;
  state_t      next_state;
  logic [15:0] next_freq;
  logic        next_dir;
  logic        next_sleep;

  // bus slave: address phase capture, write lands in the data phase
  wire         addr_take = hsel && hready && htrans[1];
  wire         addr_high = (haddr[31:8] == 24'h0) && (haddr[1:0] == 2'h0);
  wire  [5:0]  addr_idx  = haddr[7:2];
  logic        wr_pend;
  logic [5:0]  wr_idx;

  wire         wr_hit    = wr_pend && (wr_idx < 6'(NUM_CFG));
  wire         rd_cfg    = addr_high && (addr_idx < 6'(NUM_CFG));
  wire         rd_fwd    = wr_hit && (wr_idx == addr_idx);
  wire  [15:0] rd_cfgval = rd_fwd ? hwdata[15:0] : cfg[addr_idx[4:0]];
  wire  [31:0] status    = {18'h0, drive_sleep, dc_brake_on, out_enable, out_reverse, state};
  wire  [31:0] rd_mux    =
    rd_cfg ? {16'h0, rd_cfgval} :
    (addr_high && addr_idx == 6'(IDX_STATUS)) ? status :
    (addr_high && addr_idx == 6'(IDX_OUT_FREQ)) ? {16'h0, out_freq} : 32'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      wr_idx    <= 6'h00;
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend <= addr_take && hwrite && addr_high;
      wr_idx  <= addr_idx;
      if (addr_take && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NUM_CFG; i++) begin
        cfg[i] <= RESET_VAL[i];
      end
    end else if (wr_hit) begin
      cfg[wr_idx[4:0]] <= hwdata[15:0];
    end
  end

  // configuration fields
  wire [15:0] ctrl        = cfg[IDX_CTRL];
  wire [15:0] mode        = cfg[IDX_MODE];
  wire [1:0]  command_channel_sel   = mode[MODE_CHAN_LO +: 2];
  wire [1:0]  start_mode_sel        = mode[MODE_START_LO +: 2];
  wire        ramp_shape_sel        = mode[MODE_SHAPE];
  wire        stop_mode_sel         = mode[MODE_STOP];
  wire [1:0]  reversal_mode         = mode[MODE_REV_LO +: 2];
  wire        stop_speed_detect_sel = mode[MODE_DETECT];
  wire        poweron_run_protect   = mode[MODE_PROTECT];
  wire [1:0]  low_limit_action      = mode[MODE_LOWACT_LO +: 2];
  wire        low_stop_decel        = mode[MODE_LOW_DECEL];
  wire [15:0] max_freq              = cfg[IDX_MAX_FREQ];
  wire [15:0] lower_limit           = cfg[IDX_LOWER_LIMIT];
  wire [15:0] direct_start_freq     = cfg[IDX_START_FREQ];
  wire [15:0] stop_brake_start_freq = cfg[IDX_BRK_FREQ];
  wire [15:0] stop_speed_threshold  = cfg[IDX_STOP_SPEED];

  // sequencing tick
  logic [TICK_W-1:0] tick_cnt;
  logic              tick;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else begin
      tick     <= (tick_cnt == TICK_W'(TICK_CYCLES - 1));
      tick_cnt <= (tick_cnt == TICK_W'(TICK_CYCLES - 1)) ? '0 : tick_cnt + 1'b1;
    end
  end

  // terminal pins and power-on protection
  logic [1:0] term_sync;
  logic [1:0] settle;
  logic       term_block;

  seq_sync #(.WIDTH(2)) u_term_sync (
    .clk   (hclk),
    .rst_n (hresetn),
    .d     ({term_rev, term_fwd}),
    .q     (term_sync)
  );

  wire term_active = term_sync[0] || term_sync[1];

  // the synchroniser reads zero for two cycles; only a settled low releases the block
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      settle     <= 2'h0;
      term_block <= 1'b1;
    end else if (settle != 2'h3) begin
      settle <= settle + 2'h1;
    end else if (!term_active) begin
      term_block <= 1'b0;
    end
  end

  wire term_ok  = !term_block || poweron_run_protect;
  wire term_run = term_active && term_ok;
  wire term_dir = term_sync[1] && !term_sync[0];

  wire cmd_run =
    (command_channel_sel == CHAN_KEYPAD)   ? ctrl[CTRL_KEY_RUN] :
    (command_channel_sel == CHAN_TERMINAL) ? term_run :
    (command_channel_sel == CHAN_COMM)     ? ctrl[CTRL_COMM_RUN] : 1'b0;
  wire cmd_rev =
    (command_channel_sel == CHAN_KEYPAD)   ? ctrl[CTRL_KEY_REV] :
    (command_channel_sel == CHAN_TERMINAL) ? term_dir :
    (command_channel_sel == CHAN_COMM)     ? ctrl[CTRL_COMM_REV] : 1'b0;

  // lower limit handling
  wire        below    = (lower_limit != 16'h0) && (cfg[IDX_SET_FREQ] < lower_limit);
  wire        low_stop = below && (low_limit_action != LOW_RUN);
  wire [15:0] set_eff  = (below && !low_stop) ? lower_limit : cfg[IDX_SET_FREQ];
  wire [15:0] target   = (set_eff > max_freq) ? max_freq : set_eff;
  wire        run_req  = cmd_run && !low_stop;
  wire        coast    = low_stop ? !low_stop_decel : stop_mode_sel;

  // stop speed; open-loop voltage-vector mode only trusts the set speed
  wire [15:0] speed_used   = (stop_speed_detect_sel && !ctrl[CTRL_SVPWM]) ? speed_fb : out_freq;
  wire        stop_reached = (speed_used <= stop_speed_threshold);

  // ramp engine: Bresenham accumulator, one 0.01 Hz step per clock at most; zero ramp time jumps to target in one clock
  logic [23:0] acc;
  logic        ramping_d;
  logic [15:0] step_cnt;
  logic [15:0] steps_last;
  wire         st_ramp    = (state == ST_RUN) || (state == ST_STOPPING) || (state == ST_REVERSE);
  wire [15:0]  turn_freq  = (reversal_mode == REV_AT_START) ? direct_start_freq : 16'h0;
  wire [15:0]  ramp_tgt   = (state == ST_RUN) ? target :
                            (state == ST_REVERSE) ? turn_freq : 16'h0;
  wire         ramping    = st_ramp && (out_freq != ramp_tgt);
  wire         ramp_up    = out_freq < ramp_tgt;
  wire [15:0]  ramp_time  = ramp_up ? cfg[IDX_ACCEL] : cfg[IDX_DECEL];
  wire [19:0]  den        = 20'(ramp_time * TICKS_PER_DECI);
  wire [15:0]  remaining  = ramp_up ? ramp_tgt - out_freq : out_freq - ramp_tgt;
  wire [35:0]  end_zone   = steps_last * 20'(cfg[IDX_S_END] * TICKS_PER_DECI);
  logic        seg_done;
  // S curve runs at half slope in its start and end segments
  wire         half_rate  = ramp_shape_sel &&
                            (!seg_done || 36'(remaining) <= end_zone);
  wire [23:0]  acc_add    = tick ? 24'(half_rate ? max_freq >> 1 : max_freq) : 24'h0;
  wire         step_due   = ramping && ((den == 20'h0) || (acc >= 24'(den)));
  wire [23:0]  acc_sub    = (step_due && den != 20'h0) ? 24'(den) : 24'h0;
  wire [15:0]  ramp_freq  = !step_due ? out_freq :
                            (den == 20'h0) ? ramp_tgt :
                            ramp_up ? out_freq + 16'h1 : out_freq - 16'h1;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc        <= 24'h0;
      ramping_d  <= 1'b0;
      step_cnt   <= 16'h0;
      steps_last <= 16'h0;
    end else begin
      acc       <= ramping ? acc + acc_add - acc_sub : 24'h0;
      ramping_d <= ramping;
      if (tick) begin
        steps_last <= step_cnt;
        step_cnt   <= 16'h0;
      end else if (step_due && step_cnt != 16'hFFFF) begin
        step_cnt <= step_cnt + 16'h1;
      end
    end
  end

  seq_timer #(.WIDTH(20)) u_seg_timer (
    .clk      (hclk),
    .rst_n    (hresetn),
    .load     (ramping && !ramping_d),
    .load_val (20'(cfg[IDX_S_START] * TICKS_PER_DECI)),
    .tick     (tick),
    .done     (seg_done)
  );

  // phase timer shared by hold, braking, waiting and deadzone
  logic        ph_load;
  logic [19:0] ph_val;
  logic        ph_done;

  seq_timer #(.WIDTH(20)) u_phase_timer (
    .clk      (hclk),
    .rst_n    (hresetn),
    .load     (ph_load),
    .load_val (ph_val),
    .tick     (tick),
    .done     (ph_done)
  );

  wire [19:0] hold_ticks  = 20'(cfg[IDX_START_HOLD] * TICKS_PER_DECI);
  wire [19:0] turn_ticks  = 20'(cfg[IDX_DEADZONE] * TICKS_PER_DECI) +
    ((reversal_mode > REV_AT_START) ? 20'(cfg[IDX_STOP_DELAY] * TICKS_PER_DECI) : 20'h0);
  wire        turn_hit    =
    (reversal_mode == REV_AT_ZERO)  ? (out_freq == 16'h0) :
    (reversal_mode == REV_AT_START) ? (out_freq <= direct_start_freq) : stop_reached;
  wire        skip_pre    = (cfg[IDX_PRE_TIME] == 16'h0);
  wire        track_small = (start_mode_sel == START_TRACK2) && (speed_fb < stop_speed_threshold);
  wire [15:0] fb_clamped  = (speed_fb > max_freq) ? max_freq : speed_fb;

  always_comb begin
    next_state = state;
    next_freq  = st_ramp ? ramp_freq : out_freq;
    next_dir   = out_reverse;
    next_sleep = drive_sleep;
    ph_load    = 1'b0;
    ph_val     = hold_ticks;
    unique case (state)
      ST_IDLE: begin
        next_freq  = 16'h0;
        next_sleep = drive_sleep && low_stop;
        if (run_req) begin
          next_dir   = cmd_rev;
          next_sleep = 1'b0;
          if (start_mode_sel == START_DIRECT ||
              (start_mode_sel == START_BRAKE && skip_pre)) begin
            next_freq  = direct_start_freq;
            next_state = ST_HOLD;
            ph_load    = 1'b1;
          end else if (start_mode_sel == START_BRAKE) begin
            next_state = ST_PREBRAKE;
            ph_load    = 1'b1;
            ph_val     = 20'(cfg[IDX_PRE_TIME]);
          end else begin
            next_state = ST_TRACK;
          end
        end
      end
      ST_PREBRAKE: begin
        if (ph_done) begin
          next_freq  = direct_start_freq;
          next_state = ST_HOLD;
          ph_load    = 1'b1;
        end
      end
      ST_TRACK: begin
        // low feedback in the second variant falls back to a direct start
        next_freq  = track_small ? direct_start_freq : fb_clamped;
        next_state = track_small ? ST_HOLD : ST_RUN;
        ph_load    = track_small;
      end
      ST_HOLD: begin
        if (!run_req) begin
          next_state = ST_STOPPING;
        end else if (ph_done) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!run_req) begin
          next_sleep = low_stop && (low_limit_action == LOW_SLEEP);
          next_state = coast ? ST_IDLE : ST_STOPPING;
          next_freq  = coast ? 16'h0 : ramp_freq;
        end else if (cmd_rev != out_reverse) begin
          next_state = ST_REVERSE;
        end
      end
      ST_STOPPING: begin
        if (run_req) begin
          next_state = ST_RUN;
        end else if (out_freq <= stop_brake_start_freq) begin
          next_freq  = 16'h0;
          next_state = ST_BRK_WAIT;
          ph_load    = 1'b1;
          ph_val     = 20'(cfg[IDX_BRK_WAIT]);
        end
      end
      ST_BRK_WAIT: begin
        if (ph_done) begin
          next_state = (cfg[IDX_BRK_TIME] == 16'h0) ? ST_IDLE : ST_BRAKE;
          ph_load    = 1'b1;
          ph_val     = 20'(cfg[IDX_BRK_TIME]);
        end
      end
      ST_BRAKE: begin
        if (ph_done) begin
          next_state = ST_IDLE;
        end
      end
      ST_REVERSE: begin
        if (!run_req) begin
          next_state = ST_STOPPING;
        end else if (turn_hit) begin
          next_state = ST_DEADZONE;
          ph_load    = 1'b1;
          ph_val     = turn_ticks;
        end
      end
      ST_DEADZONE: begin
        next_freq = out_freq;
        if (!run_req) begin
          next_state = ST_STOPPING;
        end else if (ph_done) begin
          next_dir   = cmd_rev;
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_freq  = 16'h0;
      end
    endcase
  end

  wire pwm_on = (next_state == ST_HOLD) || (next_state == ST_RUN) ||
                (next_state == ST_STOPPING) || (next_state == ST_REVERSE) ||
                (next_state == ST_DEADZONE) || (next_state == ST_TRACK);
  wire brk_pre  = (next_state == ST_PREBRAKE);
  wire brk_stop = (next_state == ST_BRAKE);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state          <= ST_IDLE;
      out_freq       <= 16'h0;
      out_reverse    <= 1'b0;
      out_enable     <= 1'b0;
      dc_brake_on    <= 1'b0;
      dc_brake_level <= 16'h0;
      drive_running  <= 1'b0;
      drive_sleep    <= 1'b0;
    end else begin
      state          <= next_state;
      out_freq       <= next_freq;
      out_reverse    <= next_dir;
      out_enable     <= pwm_on;
      dc_brake_on    <= brk_pre || brk_stop;
      dc_brake_level <= brk_pre ? cfg[IDX_PRE_CUR] :
                        brk_stop ? cfg[IDX_BRK_CUR] : 16'h0;
      drive_running  <= pwm_on || brk_pre || brk_stop;
      drive_sleep    <= next_sleep;
    end
  end

endmodule

// File: bench/seq_properties.sv
/* Port checker for the start/stop sequencer.
   Bound into every sequencer instance; sees only its ports. */
`timescale 1ns/1ps

module seq_properties (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        out_enable,
  input wire logic        dc_brake_on,
  input wire logic [15:0] dc_brake_level,
  input wire logic        drive_running
);
  logic cfg_seen;
  wire  taken = hsel & hready & htrans[1];

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // until the first write the keypad channel is idle, so nothing may move
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cfg_seen <= 1'b0;
    else if (taken & hwrite) cfg_seen <= 1'b1;
  end

  property p_idle_quiet; !drive_running |-> !out_enable && !dc_brake_on; endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("idle drive active");
  property p_lvl_zero; !dc_brake_on |-> dc_brake_level == 16'h0000; endproperty
  a_lvl_zero: assert property (p_lvl_zero) else $error("level without brake");
  property p_brk_no_out; dc_brake_on |-> !out_enable; endproperty
  a_brk_no_out: assert property (p_brk_no_out) else $error("brake with output");
  property p_out_run; out_enable |-> drive_running; endproperty
  a_out_run: assert property (p_out_run) else $error("output not running");
  property p_brk_run; dc_brake_on |-> drive_running; endproperty
  a_brk_run: assert property (p_brk_run) else $error("brake not running");
  property p_no_cfg; !cfg_seen |-> !drive_running; endproperty
  a_no_cfg: assert property (p_no_cfg) else $error("run with no command");
  property p_rd_hold; !(taken && !hwrite) |=> $stable(hrdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus wait or error");

  c_start: cover property ($rose(out_enable));
  c_brake: cover property ($rose(dc_brake_on));
  c_stop: cover property ($fell(drive_running));
endmodule

bind motor_start_stop_sequencer seq_properties i_props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .out_enable(out_enable), .dc_brake_on(dc_brake_on), .dc_brake_level(dc_brake_level),
  .drive_running(drive_running));

// File: bench/tb_top.sv
/* Self-checking bench for the sequencer over an AHB-Lite master.
   Assumes package, design and checker compiled before it. */
`timescale 1ns/1ps

module tb_top;
  import seq_pkg::*;
  typedef struct {int a; logic [31:0] e; logic [31:0] m;} note_t;
  localparam logic [15:0] CFG [NUM_CFG] = '{16'h0000, 16'h0100, 16'h0BB8, 16'h1770,
    16'h0000, 16'h0100, 16'h0001, 16'h0300, 16'h0005, 16'h0001, 16'h0001, 16'h0001,
    16'h0001, 16'h0200, 16'h0002, 16'h01F4, 16'h0003, 16'h0000, 16'h0032, 16'h0000};
  localparam logic [31:0] SX [4] = '{32'h808, 32'h1002, 32'h800, 32'h800};
  localparam logic [31:0] SM [4] = '{32'h3FFF, 32'h3FFF, 32'h1800, 32'h1800};
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_pend = 1'b0;
  logic        term_fwd = 1'b1, term_rev = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rv, wv;
  logic [15:0] speed_fb = 16'h0, fb, out_freq, dc_brake_level;
  logic        hreadyout, hresp, out_reverse, out_enable, dc_brake_on;
  logic        drive_running, drive_sleep;
  int          err_count = 0, cmp_count = 0, seed = 32'h1038;
  note_t       q[$];
  note_t       nt;

  always #50 hclk = ~hclk;

  motor_start_stop_sequencer #(.TICK_CYCLES(20)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .term_fwd(term_fwd), .term_rev(term_rev),
    .speed_fb(speed_fb), .out_freq(out_freq), .out_reverse(out_reverse),
    .out_enable(out_enable), .dc_brake_on(dc_brake_on), .dc_brake_level(dc_brake_level),
    .drive_running(drive_running), .drive_sleep(drive_sleep));

  task automatic final_report;
    if (err_count == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic give_up;
    err_count++;
    final_report();
  endtask

  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) give_up();
      @(posedge hclk);
    end
  endtask

  // note queued before the request, so the watcher never finds it missing
  task automatic bus(input logic w, input int i, input logic [31:0] d, e, m);
    if (!w) q.push_back('{i * 4, e, m});
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= 32'(i * 4);
    hwrite <= w;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rv = hrdata;
  endtask

  task automatic wr(input int i, input logic [31:0] d);
    bus(1'b1, i, d, 32'h0, 32'h0);
  endtask

  task automatic rd(input int i, input logic [31:0] e, input logic [31:0] m);
    bus(1'b0, i, 32'h0, e, m);
  endtask

  task automatic poll(input int i, input logic [31:0] e, input logic [31:0] m);
    int n;
    n = 0;
    rd(i, 32'h0, 32'h0);
    while ((rv & m) !== (e & m)) begin
      n++;
      if (n > 3000) give_up();
      rd(i, 32'h0, 32'h0);
    end
  endtask

  // zero mask marks a poll or unchecked read: taken off the queue unchecked
  always @(posedge hclk) begin
    if (rd_pend) begin
      nt = q.pop_front();
      if (nt.m !== 32'h0) check($sformatf("reg %0d", nt.a), hrdata & nt.m, nt.e & nt.m);
    end
    rd_pend = hsel && htrans[1] && !hwrite && hreadyout;
  end

  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < NUM_CFG; i++) rd(i, {16'h0, RESET_VAL[i]}, '1);
    wr(IDX_STATUS, 32'hFFFF);
    wr(40, 32'hFFFF);
    rd(IDX_STATUS, 32'h1, '1);
    rd(40, 32'h0, '1);
    for (int i = IDX_SET_FREQ; i < NUM_CFG; i++) begin
      wv = $random(seed);
      wr(i, wv);
      rd(i, wv & 32'hFFFF, '1);
    end
    for (int i = 0; i < NUM_CFG; i++) wr(i, {16'h0, CFG[i]});
    for (int s = 0; s < 4; s++) begin
      fb = 16'h0400 + 16'($random(seed) & 32'h3FF);
      speed_fb <= fb;
      wr(IDX_SET_FREQ, {16'h0, fb});
      wr(IDX_MODE, 32'h0120 | 32'(s << 2) | (s == 0 ? 32'h10 : 32'h0));
      wr(IDX_CTRL, 32'h1);
      repeat (3) @(posedge hclk);
      rd(IDX_STATUS, SX[s], SM[s]);
      rd(IDX_OUT_FREQ, s > 1 ? {16'h0, fb} : 32'h100, s == 1 ? 32'h0 : '1);
      if (s == 1) check("brake level", {16'h0, dc_brake_level}, 32'h0300);
      poll(IDX_OUT_FREQ, {16'h0, fb}, '1);
      rd(IDX_STATUS, 32'h810, 32'h3FFF);
      wr(IDX_CTRL, 32'h0);
      repeat (3) @(posedge hclk);
      rd(IDX_STATUS, 32'h1, 32'h3FFF);
    end
    // decelerating stop with braking after a reversal and a lower-limit run
    wr(IDX_MODE, 32'h0100);
    wr(IDX_CTRL, 32'h1);
    poll(IDX_STATUS, 32'h810, 32'h3FFF);
    wr(IDX_CTRL, 32'h3);
    poll(IDX_STATUS, 32'h400, 32'h400);
    poll(IDX_OUT_FREQ, {16'h0, fb}, '1);
    rd(IDX_STATUS, 32'hC10, 32'h3FFF);
    wr(IDX_LOWER_LIMIT, 32'h0800);
    wr(IDX_SET_FREQ, 32'h0400);
    poll(IDX_OUT_FREQ, 32'h0800, '1);
    rd(IDX_STATUS, 32'hC10, 32'h3FFF);
    wr(IDX_MODE, 32'h2100);
    poll(IDX_STATUS, 32'h2001, 32'h3BFF);
    rd(IDX_STATUS, 32'h2401, 32'h3FFF);
    wr(IDX_LOWER_LIMIT, 32'h0);
    poll(IDX_OUT_FREQ, 32'h0400, '1);
    rd(IDX_STATUS, 32'h0C10, 32'h3FFF);
    wr(IDX_CTRL, 32'h0);
    poll(IDX_STATUS, 32'h040, 32'h3BFF);
    rd(IDX_OUT_FREQ, 32'h0, 32'h0);
    check("freq at brake wait", {31'h0, rv <= 32'h0200}, 32'h1);
    poll(IDX_STATUS, 32'h1080, 32'h3BFF);
    check("brake level", {16'h0, dc_brake_level}, 32'h01F4);
    poll(IDX_STATUS, 32'h1, 32'h3BFF);
    // terminal held high since power-up must not start the drive
    wr(IDX_MODE, 32'h0121);
    wr(IDX_CTRL, 32'h1);
    repeat (6) @(posedge hclk);
    rd(IDX_STATUS, 32'h1, 32'h3BFF);
    wr(IDX_CTRL, 32'h0);
    term_fwd <= 1'b0;
    repeat (6) @(posedge hclk);
    term_fwd <= 1'b1;
    repeat (6) @(posedge hclk);
    rd(IDX_STATUS, 32'h808, 32'h3FFF);
    final_report();
  end
endmodule
